// ==== logic/smc_socket_misc_regs.sv ====
`timescale 1ns/1ps
`include "smc_defs.svh"
// Function
// - Ring enable routes ring to ring/PME pin when mux is 0, and terminals 2/4.
// - Video pass-through enable puts that socket's video terminals in high impedance.
// - Both sockets in video mode: port select picks which select line asserts.
// - Card control bits 4-3 are read-only zero.
// - Audio route enable sends card audio to PWM output; socket 0 wins.
// - Speaker route enable sends speaker signals, both sockets XORed, to output.
// - Speaker output driven only while either socket's speaker enable is set.
// - Per-socket interrupt flag set by card interrupt, cleared by writing 1.
// - Device control is one copy shared by both functions.
// - Device control bit 6 forces 3-V capability report, reset 1.
// - Device control bit 5 is a read/write diagnostic bit, reset 1.
// - Device control bits 7 and 4 read zero, writes ignored.
// - Device control bits 2-1 select interrupt signaling mode, reset 11.
// - Diagnostic register fully read/write, reset 0x61; host writes zeros.
module smc_socket_misc_regs
    import smc_pkg::*;
#(
    parameter int ADDR_W = 11
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Socket pins, one bit per socket except the single ring source pin
    input wire logic [1:0] card_irq_pin,
    input wire logic [1:0] card_audio_signal,
    input wire logic [1:0] card_speaker_signal,
    input wire logic ring_source_pin,
    // Same-clock control from the terminal mapping logic
    input wire logic ring_mux_select,
    // Routed outputs
    output logic ring_pme_output,
    output logic multi_terminal_2,
    output logic multi_terminal_4,
    output logic audio_pwm_output,
    output logic speaker_output,
    output logic speaker_output_oe,
    output smc_video_type video_out,
    // Global configuration outputs
    output logic [1:0] low_voltage_capable,
    output logic [1:0] irq_signaling_mode,
    output logic [7:0] diag_value,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change accepted when 2 and 3 agree

    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] sync3_reg;
    logic [NSYNC-1:0] pin_reg;

    assign pin_raw = {ring_source_pin, card_speaker_signal,
                      card_audio_signal, card_irq_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    sync3_reg[gi] <= 1'b0;
                    pin_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        pin_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    logic [1:0] irq_lvl;
    logic [1:0] audio_lvl;
    logic [1:0] spk_lvl;
    logic ring_lvl;
    assign irq_lvl = pin_reg[1:0];
    assign audio_lvl = pin_reg[3:2];
    assign spk_lvl = pin_reg[5:4];
    assign ring_lvl = pin_reg[6];

    // Functional interrupt event is the rising edge of the filtered level
    logic [1:0] irq_prev_reg;
    logic [1:0] irq_event;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_prev_reg <= 2'h0;
        end else begin
            irq_prev_reg <= irq_lvl;
        end
    end
    assign irq_event = irq_lvl & ~irq_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, read data registered with the answer

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a[9:2] == idx);
    endfunction : hit

    logic func_sel;
    logic wr_go;
    logic [7:0] wbyte;
    assign func_sel = address[10];
    assign wr_go = write && !waitrequest && byteenable[0];
    assign wbyte = writedata[7:0];

    smc_card_ctrl_type card_reg [2];
    smc_dev_ctrl_type dev_reg;
    logic [7:0] diag_reg;
    logic ring_en_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_enable_reg;
    logic [7:0] rd_next;

    always_comb begin
        rd_next = 8'h00;
        if (hit(address, `SMC_IDX_CARD_CTRL)) begin
            rd_next = card_reg[func_sel] & `SMC_CARD_CTRL_WMASK |
                      {7'h00, card_reg[func_sel].functional_irq_flag};
            rd_next[`SMC_CARD_RING_BIT] = ring_en_reg;
        end else if (hit(address, `SMC_IDX_DEV_CTRL)) begin
            rd_next = dev_reg & `SMC_DEV_CTRL_WMASK;
        end else if (hit(address, `SMC_IDX_DIAG)) begin
            rd_next = diag_reg;
        end else if (hit(address, `SMC_IDX_IRQ_STATUS) && !func_sel) begin
            rd_next = {6'h00, irq_status_reg};
        end else if (hit(address, `SMC_IDX_IRQ_ENABLE) && !func_sel) begin
            rd_next = {6'h00, irq_enable_reg};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
            readdata <= {24'h00_0000, rd_next};
        end else begin
            waitrequest <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Card control, one copy per socket function; ring enable is global

    generate
        for (gi = 0; gi < 2; gi++) begin : g_card
            logic wr_card;
            assign wr_card = wr_go && hit(address, `SMC_IDX_CARD_CTRL) &&
                             (func_sel == 1'(gi));
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    card_reg[gi] <= `SMC_CARD_CTRL_RESET;
                end else begin
                    if (wr_card) begin
                        card_reg[gi].video_passthru_enable <= wbyte[6];
                        card_reg[gi].port_select <= wbyte[5];
                        card_reg[gi].card_audio_route_enable <= wbyte[2];
                        card_reg[gi].speaker_route_enable <= wbyte[1];
                    end
                    card_reg[gi].reserved <= 2'h0;
                    card_reg[gi].ring_out_enable <= 1'b0;
                    // Set beats clear; writing 0 leaves the flag alone
                    if (irq_event[gi]) begin
                        card_reg[gi].functional_irq_flag <= 1'b1;
                    end else if (wr_card && wbyte[`SMC_CARD_IFG_BIT]) begin
                        card_reg[gi].functional_irq_flag <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Software is expected to use function 0 here; either function
    // reaches the one shared copy so a stray write still lands somewhere
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ring_en_reg <= 1'b0;
        end else if (wr_go && hit(address, `SMC_IDX_CARD_CTRL)) begin
            ring_en_reg <= wbyte[`SMC_CARD_RING_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Device control and diagnostic: single shared copies

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dev_reg <= `SMC_DEV_CTRL_RESET;
        end else if (wr_go && hit(address, `SMC_IDX_DEV_CTRL)) begin
            dev_reg <= wbyte & `SMC_DEV_CTRL_WMASK;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            diag_reg <= `SMC_DIAG_RESET;
        end else if (wr_go && hit(address, `SMC_IDX_DIAG)) begin
            diag_reg <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, clear and enable

    logic [1:0] clr_bits;
    assign clr_bits = (wr_go && !func_sel &&
                       hit(address, `SMC_IDX_IRQ_CLEAR)) ? wbyte[1:0] : 2'h0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_reg <= 2'h0;
        end else begin
            irq_status_reg <= irq_event | (irq_status_reg & ~clr_bits);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_enable_reg <= 2'h0;
        end else if (wr_go && !func_sel &&
                     hit(address, `SMC_IDX_IRQ_ENABLE)) begin
            irq_enable_reg <= wbyte[1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Signal routing, all outputs registered

    logic zv0;
    logic zv1;
    logic [1:0] spk_en;
    assign zv0 = card_reg[0].video_passthru_enable;
    assign zv1 = card_reg[1].video_passthru_enable;
    assign spk_en = {card_reg[1].speaker_route_enable,
                     card_reg[0].speaker_route_enable};

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ring_pme_output <= 1'b0;
            multi_terminal_2 <= 1'b0;
            multi_terminal_4 <= 1'b0;
        end else begin
            ring_pme_output <= ring_en_reg && !ring_mux_select &&
                               ring_lvl;
            multi_terminal_2 <= ring_en_reg && ring_lvl;
            multi_terminal_4 <= ring_en_reg && ring_lvl;
        end
    end

    // Priority bit is taken from function 0's copy
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            video_out <= '0;
        end else begin
            video_out.zoomed_video_hiz <= {zv1, zv0};
            video_out.video_select_0 <= zv0 &&
                (!zv1 || !card_reg[0].port_select);
            video_out.video_select_1 <= zv1 &&
                (!zv0 || card_reg[0].port_select);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            audio_pwm_output <= 1'b0;
        end else if (card_reg[0].card_audio_route_enable) begin
            audio_pwm_output <= audio_lvl[0];
        end else if (card_reg[1].card_audio_route_enable) begin
            audio_pwm_output <= audio_lvl[1];
        end else begin
            audio_pwm_output <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            speaker_output <= 1'b0;
            speaker_output_oe <= 1'b0;
        end else begin
            speaker_output <= |(spk_en & spk_lvl) && ^(spk_en & spk_lvl);
            speaker_output_oe <= |spk_en;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            low_voltage_capable <= 2'h0;
            irq_signaling_mode <= 2'h0;
            diag_value <= 8'h00;
        end else begin
            low_voltage_capable <=
                {2{dev_reg.low_voltage_capable_force}};
            irq_signaling_mode <= dev_reg.irq_signaling_mode;
            diag_value <= diag_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    flag_set_wins_a: assert property (
        irq_event[0] |=> card_reg[0].functional_irq_flag)
        else $error("card irq flag lost its set");

    flag_hold_zero_a: assert property (
        card_reg[1].functional_irq_flag && !irq_event[1] &&
        !(wr_go && func_sel && hit(address, `SMC_IDX_CARD_CTRL) &&
          wbyte[0]) |=> card_reg[1].functional_irq_flag)
        else $error("card irq flag dropped without a clear");

    speaker_drive_a: assert property (
        speaker_output_oe == $past(|spk_en) && (!speaker_output_oe ->
        !speaker_output))
        else $error("speaker driven while disabled");

    speaker_xor_a: assert property (
        ##1 speaker_output == $past(^(spk_en & spk_lvl)))
        else $error("speaker is not the xor of enabled sockets");

    video_prio_a: assert property (
        zv0 && zv1 |=> video_out.video_select_0 !=
        video_out.video_select_1 &&
        video_out.video_select_1 == $past(card_reg[0].port_select))
        else $error("video select priority broken");

    audio_prio_a: assert property (
        card_reg[0].card_audio_route_enable |=>
        audio_pwm_output == $past(audio_lvl[0]))
        else $error("audio not from socket 0");

    ring_route_a: assert property (
        !ring_en_reg ##1 !ring_en_reg |-> !multi_terminal_2 &&
        !multi_terminal_4 && !ring_pme_output)
        else $error("ring routed while disabled");

    dev_reserved_a: assert property (
        dev_reg.reserved_7 == 1'b0 && dev_reg.reserved_4 == 1'b0 &&
        card_reg[0].reserved == 2'h0)
        else $error("reserved bits set");

    bus_answer_a: assert property (
        (read && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one wait cycle");

endmodule : smc_socket_misc_regs

// ==== logic/smc_defs.svh ====
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// Register indices; byte address is four times the index
`define SMC_IDX_CARD_CTRL 8'h91
`define SMC_IDX_DEV_CTRL 8'h92
`define SMC_IDX_DIAG 8'h93
`define SMC_IDX_IRQ_STATUS 8'ha0
`define SMC_IDX_IRQ_CLEAR 8'ha1
`define SMC_IDX_IRQ_ENABLE 8'ha2

// Reset values
`define SMC_CARD_CTRL_RESET 8'h00
`define SMC_DEV_CTRL_RESET 8'h66
`define SMC_DIAG_RESET 8'h61

// Writable bit masks
`define SMC_CARD_CTRL_WMASK 8'he6
`define SMC_DEV_CTRL_WMASK 8'h6f

// Field positions
`define SMC_CARD_RING_BIT 7
`define SMC_CARD_IFG_BIT 0

// Bus answer latency in clocks after the request is first seen
`define SMC_BUS_WAIT_CYCLES 1

`endif

// ==== logic/smc_pkg.sv ====
package smc_pkg;

    typedef struct packed {
        logic ring_out_enable;
        logic video_passthru_enable;
        logic port_select;
        logic [1:0] reserved;
        logic card_audio_route_enable;
        logic speaker_route_enable;
        logic functional_irq_flag;
    } smc_card_ctrl_type;

    typedef struct packed {
        logic reserved_7;
        logic low_voltage_capable_force;
        logic diag_bit_five;
        logic reserved_4;
        logic vendor_test;
        logic [1:0] irq_signaling_mode;
        logic global_test;
    } smc_dev_ctrl_type;

    typedef struct packed {
        logic video_select_0;
        logic video_select_1;
        logic [1:0] zoomed_video_hiz;
    } smc_video_type;

endpackage : smc_pkg

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "smc_defs.svh"
module tb_top;
    import smc_pkg::*;

    `define CHK(nm, e, g) cmp(nm, 32'(e), 32'(g))

    localparam logic [7:0] CC = `SMC_IDX_CARD_CTRL;
    localparam logic [7:0] DC = `SMC_IDX_DEV_CTRL;
    localparam logic [7:0] DG = `SMC_IDX_DIAG;
    localparam logic [7:0] IS = `SMC_IDX_IRQ_STATUS;
    localparam logic [7:0] IC = `SMC_IDX_IRQ_CLEAR;
    localparam logic [7:0] IE = `SMC_IDX_IRQ_ENABLE;

    logic clock;
    logic rst_b;
    logic read;
    logic write;
    logic [10:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] card_irq_pin;
    logic [1:0] card_audio_signal;
    logic [1:0] card_speaker_signal;
    logic ring_source_pin;
    logic ring_mux_select;
    logic ring_pme_output;
    logic multi_terminal_2;
    logic multi_terminal_4;
    logic audio_pwm_output;
    logic speaker_output;
    logic speaker_output_oe;
    smc_video_type video_out;
    logic [1:0] low_voltage_capable;
    logic [1:0] irq_signaling_mode;
    logic [7:0] diag_value;
    logic irq;
    int num_errors;
    int check_count;

    smc_socket_misc_regs #(.ADDR_W(11)) dut_u (
        .clock(clock), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .card_irq_pin(card_irq_pin), .card_audio_signal(card_audio_signal),
        .card_speaker_signal(card_speaker_signal),
        .ring_source_pin(ring_source_pin), .ring_mux_select(ring_mux_select),
        .ring_pme_output(ring_pme_output), .multi_terminal_2(multi_terminal_2),
        .multi_terminal_4(multi_terminal_4),
        .audio_pwm_output(audio_pwm_output), .speaker_output(speaker_output),
        .speaker_output_oe(speaker_output_oe), .video_out(video_out),
        .low_voltage_capable(low_voltage_capable),
        .irq_signaling_mode(irq_signaling_mode), .diag_value(diag_value),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic cmp(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // Holds the request until waitrequest is seen low; no latency assumed
    task automatic bus(input logic f, input logic [7:0] idx,
                       input logic is_wr, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        @(posedge clock);
        address <= {f, idx, 2'b00};
        writedata <= {24'h0, wd};
        write <= is_wr;
        read <= !is_wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            $display("MISMATCH waitrequest expected 0 seen 1");
        end
    endtask : bus

    task automatic wr(input logic f, input logic [7:0] idx, d);
        logic [7:0] x;
        bus(f, idx, 1'b1, d, x);
    endtask : wr

    task automatic chk(input string nm, input logic f,
                       input logic [7:0] idx, e);
        logic [7:0] x;
        bus(f, idx, 1'b0, 8'h00, x);
        `CHK(nm, e, x);
    endtask : chk

    // Pins pass a synchroniser and filter, so allow generous settling
    task automatic pins(input logic [1:0] a, s, input logic r, m);
        @(posedge clock);
        card_audio_signal <= a;
        card_speaker_signal <= s;
        ring_source_pin <= r;
        ring_mux_select <= m;
        repeat (8) @(posedge clock);
    endtask : pins

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        print_verdict();
    end

    initial begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 11'h000;
        byteenable = 4'hf;
        writedata = 32'h0;
        card_irq_pin = 2'b00;
        card_audio_signal = 2'b00;
        card_speaker_signal = 2'b00;
        ring_source_pin = 1'b0;
        ring_mux_select = 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK("lv_cap", 2'b11, low_voltage_capable);
        `CHK("mode", 2'b11, irq_signaling_mode);
        `CHK("diag_out", 8'h61, diag_value);
        chk("cc0 rst", 1'b0, CC, 8'h00);
        chk("cc1 rst", 1'b1, CC, 8'h00);
        chk("dc rst", 1'b0, DC, 8'h66);
        chk("dg rst", 1'b0, DG, 8'h61);
        chk("ie rst", 1'b0, IE, 8'h00);
        $display("test reset done");

        // Device control: writable mask, shared copy, every mode
        // Test bits 3 and 0 only ever get 0; global bits via function 0
        wr(1'b0, DC, 8'hd0);
        chk("dc d0", 1'b1, DC, 8'h40);
        wr(1'b0, DC, 8'h00);
        chk("dc 00", 1'b1, DC, 8'h00);
        repeat (3) @(posedge clock);
        `CHK("lv_cap 0", 2'b00, low_voltage_capable);
        for (int m = 0; m < 4; m++) begin
            wr(1'b0, DC, {5'b01100, m[1:0], 1'b0});
            repeat (3) @(posedge clock);
            `CHK("mode", m[1:0], irq_signaling_mode);
            chk("dc mode", 1'b1, DC, {5'b01100, m[1:0], 1'b0});
        end
        wr(1'b0, DG, 8'h00);
        chk("dg 00", 1'b1, DG, 8'h00);
        repeat (3) @(posedge clock);
        `CHK("diag_out 00", 8'h00, diag_value);
        $display("test device control done");

        // Card control: reserved bits, shared ring enable, routing
        wr(1'b0, CC, 8'hff);
        chk("cc0 ff", 1'b0, CC, 8'he6);
        chk("cc1 ring", 1'b1, CC, 8'h80);
        // Function 1 writes carry back the shared ring enable unchanged
        wr(1'b1, CC, 8'he6);
        pins(2'b10, 2'b11, 1'b1, 1'b0);
        `CHK("pme", 1'b1, ring_pme_output);
        `CHK("mt2", 1'b1, multi_terminal_2);
        `CHK("mt4", 1'b1, multi_terminal_4);
        `CHK("hiz", 2'b11, video_out.zoomed_video_hiz);
        `CHK("sel0", 1'b0, video_out.video_select_0);
        `CHK("sel1", 1'b1, video_out.video_select_1);
        `CHK("aud s0 wins", 1'b0, audio_pwm_output);
        `CHK("spk xor 11", 1'b0, speaker_output);
        `CHK("spk oe", 1'b1, speaker_output_oe);
        pins(2'b01, 2'b01, 1'b1, 1'b1);
        `CHK("pme mux1", 1'b0, ring_pme_output);
        `CHK("mt2 mux1", 1'b1, multi_terminal_2);
        `CHK("aud s0", 1'b1, audio_pwm_output);
        `CHK("spk xor 01", 1'b1, speaker_output);
        wr(1'b0, CC, 8'h80);
        pins(2'b10, 2'b10, 1'b1, 1'b0);
        `CHK("hiz s1", 2'b10, video_out.zoomed_video_hiz);
        `CHK("aud s1", 1'b1, audio_pwm_output);
        `CHK("spk s1", 1'b1, speaker_output);
        `CHK("spk oe s1", 1'b1, speaker_output_oe);
        wr(1'b1, CC, 8'h80);
        repeat (3) @(posedge clock);
        `CHK("spk oe off", 1'b0, speaker_output_oe);
        wr(1'b0, CC, 8'h40);
        wr(1'b1, CC, 8'h40);
        repeat (3) @(posedge clock);
        `CHK("sel0 ps0", 1'b1, video_out.video_select_0);
        `CHK("sel1 ps0", 1'b0, video_out.video_select_1);
        `CHK("mt4 off", 1'b0, multi_terminal_4);
        $display("test card control done");

        // Functional interrupt flag, status, enable and clear
        wr(1'b0, IE, 8'h01);
        @(posedge clock);
        card_irq_pin <= 2'b01;
        repeat (10) @(posedge clock);
        `CHK("irq set", 1'b1, irq);
        chk("flag s0", 1'b0, CC, 8'h41);
        chk("flag s1", 1'b1, CC, 8'h40);
        chk("status", 1'b0, IS, 8'h01);
        wr(1'b0, CC, 8'h60);
        chk("flag kept", 1'b0, CC, 8'h61);
        wr(1'b0, CC, 8'h61);
        chk("flag clr", 1'b0, CC, 8'h60);
        wr(1'b0, IE, 8'h00);
        repeat (3) @(posedge clock);
        `CHK("irq masked", 1'b0, irq);
        wr(1'b0, IE, 8'h01);
        repeat (3) @(posedge clock);
        `CHK("irq unmasked", 1'b1, irq);
        chk("clr reads 0", 1'b0, IC, 8'h00);
        wr(1'b0, IC, 8'h01);
        repeat (3) @(posedge clock);
        `CHK("irq cleared", 1'b0, irq);
        chk("status clr", 1'b0, IS, 8'h00);
        chk("status f1", 1'b1, IS, 8'h00);
        card_irq_pin <= 2'b11;
        repeat (10) @(posedge clock);
        chk("flag s1 set", 1'b1, CC, 8'h41);
        wr(1'b1, CC, 8'h41);
        chk("flag s1 clr", 1'b1, CC, 8'h40);
        chk("unmapped", 1'b0, 8'h50, 8'h00);
        $display("test interrupt done");
        print_verdict();
    end

endmodule : tb_top
